//--- design/sseh_defines.svh
`ifndef SSEH_DEFINES_SVH
`define SSEH_DEFINES_SVH
// Functional notes
// - Save command writes working configuration into non-volatile storage.
// - Count completed saves; warn with wear code once count exceeds 1000.
// - Always attempt the write, whatever the save count holds.
// - Save asks for confirmation; only upper-case Y lets it proceed.
// - Non-Y save answer with altered transmission settings restores stored ones.
// - Characters between save letter and carriage return give parameter-count error.
// - Failed non-volatile write reports save-failure code.
// - Successful save replies with success message and running save total.
// - Save answered N is abandoned without writing, aborted message sent.
// - Save answered lower-case y is abandoned and invalid-parameter code reported.
// - Exit n goes to normal mode, confirming with Y when settings unsaved.
// - Exit n and i wait 3 seconds after the response before switching.
// - Exit i goes to init mode with the same confirmation when unsaved.
// - Entering init mode reloads settings from non-volatile storage.
// - Exit N switches to normal mode at once, no confirmation, no hold.
// - Exit I switches to init mode at once, no confirmation, no hold, reloading.
// - Unknown command, wrong count, out-of-range value give their error codes.
// - Carrying out a transfer to normal mode sends a returning message.
// - Exit confirmation other than Y or N reports invalid parameter, stays.

// Characters
`define SSEH_CH_CR 8'h0D
`define SSEH_CH_SP 8'h20
`define SSEH_CH_SAVE 8'h73
`define SSEH_CH_EXIT 8'h78
`define SSEH_CH_UY 8'h59
`define SSEH_CH_UN 8'h4E
`define SSEH_CH_LY 8'h79
`define SSEH_CH_LN 8'h6E
`define SSEH_CH_LI 8'h69
`define SSEH_CH_UI 8'h49
// Save counter
`define SSEH_SAVE_LIMIT 16'h03E8
`define SSEH_CNT_RST 16'h0000
// Timing
`define SSEH_CLK_HZ 25000000
`define SSEH_HOLD_MS 3000
`define SSEH_HOLD_CYCLES ((`SSEH_CLK_HZ / 1000) * `SSEH_HOLD_MS)
`endif

//--- design/sseh_pkg.sv
package sseh_pkg;
   // Message codes toward the text formatter
   typedef enum logic [3:0] {
      MSG_NONE = 4'h0,
      MSG_SAVE_PROMPT = 4'h1,
      MSG_SAVE_OK = 4'h2,
      MSG_SAVE_ABORT = 4'h3,
      MSG_EXIT_PROMPT = 4'h4,
      MSG_RET_NORMAL = 4'h5,
      MSG_RET_INIT = 4'h6,
      MSG_E001 = 4'h7,
      MSG_E002 = 4'h8,
      MSG_E003 = 4'h9,
      MSG_E004 = 4'hA,
      MSG_E005 = 4'hB
   } sseh_msg_type;

   typedef struct packed {
      sseh_msg_type code;
      logic [15:0] count;
   } sseh_resp_type;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SAVE_END = 4'h1,
      ST_SAVE_CONF = 4'h2,
      ST_SAVE_WR = 4'h3,
      ST_SAVE_WARN = 4'h4,
      ST_EXIT_SP = 4'h5,
      ST_EXIT_ARG = 4'h6,
      ST_EXIT_END = 4'h7,
      ST_EXIT_CONF = 4'h8,
      ST_HOLD = 4'h9,
      ST_SKIP = 4'hA
   } sseh_state_type;
endpackage : sseh_pkg

//--- design/sseh_top.sv
`timescale 1ns/1ps
`include "sseh_defines.svh"
module sseh_top import sseh_pkg::*; #(
   parameter int HOLD_CYCLES = `SSEH_HOLD_CYCLES,
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic cfg_changed,
   input wire logic tx_changed,
   input wire logic nvm_done,
   input wire logic nvm_fail,
   output logic resp_valid,
   output sseh_resp_type resp,
   output logic nvm_write,
   output logic restore_tx,
   output logic reload_cfg,
   output logic go_normal,
   output logic go_init,
   output logic unsaved,
   output logic busy
);

   sseh_state_type state_ff, nxt_state;
   logic [CNT_W-1:0] save_cnt_ff, nxt_save_cnt;
   logic [31:0] hold_ff, nxt_hold;
   logic target_init_ff, nxt_target_init;
   logic fast_ff, nxt_fast;
   sseh_msg_type skip_err_ff, nxt_skip_err;
   logic unsaved_ff, tx_dirty_ff;
   logic resp_valid_ff, nxt_resp_valid;
   sseh_resp_type resp_ff, nxt_resp;
   logic nvm_write_ff, nxt_nvm_write;
   logic restore_tx_ff, nxt_restore_tx;
   logic reload_ff, nxt_reload;
   logic go_normal_ff, nxt_go_normal;
   logic go_init_ff, nxt_go_init;
   logic busy_ff;
   logic save_clr, reload_clr;

   // Character decode, shared by the states that read characters (all but ST_SAVE_WR, ST_SAVE_WARN and ST_HOLD)
   wire is_cr = rx_valid && (rx_char == `SSEH_CH_CR);
   wire is_sp = rx_valid && (rx_char == `SSEH_CH_SP);
   wire is_uy = rx_valid && (rx_char == `SSEH_CH_UY);
   wire is_un = rx_valid && (rx_char == `SSEH_CH_UN);
   wire is_ly = rx_valid && (rx_char == `SSEH_CH_LY);
   wire arg_n = rx_char == `SSEH_CH_LN;
   wire arg_i = rx_char == `SSEH_CH_LI;
   wire arg_bn = rx_char == `SSEH_CH_UN;
   wire arg_bi = rx_char == `SSEH_CH_UI;
   wire arg_ok = arg_n || arg_i || arg_bn || arg_bi;
   wire [CNT_W-1:0] cnt_inc = save_cnt_ff + CNT_W'(1);
   wire [CNT_W-1:0] cnt_sat = (&save_cnt_ff) ? save_cnt_ff : cnt_inc;
   // Wear warning compares the updated total against the limit
   wire over_limit = cnt_sat > CNT_W'(`SSEH_SAVE_LIMIT);
   wire hold_done = hold_ff == 32'(HOLD_CYCLES - 1);
   // Busy is registered from the next state so it lines up with the state register
   wire nxt_busy = (nxt_state == ST_SAVE_WR) || (nxt_state == ST_HOLD);

   // Main sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_save_cnt = save_cnt_ff;
      nxt_hold = hold_ff;
      nxt_target_init = target_init_ff;
      nxt_fast = fast_ff;
      nxt_skip_err = skip_err_ff;
      nxt_resp_valid = 1'b0;
      nxt_resp = resp_ff;
      nxt_nvm_write = 1'b0;
      nxt_restore_tx = 1'b0;
      nxt_reload = 1'b0;
      nxt_go_normal = 1'b0;
      nxt_go_init = 1'b0;
      save_clr = 1'b0;
      reload_clr = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (rx_valid && !is_cr) begin
               if (rx_char == `SSEH_CH_SAVE) begin
                  nxt_state = ST_SAVE_END;
               end else if (rx_char == `SSEH_CH_EXIT) begin
                  nxt_state = ST_EXIT_SP;
               end else begin
                  nxt_skip_err = MSG_E001;
                  nxt_state = ST_SKIP;
               end
            end
         end
         ST_SAVE_END: begin
            if (is_cr) begin
               nxt_resp_valid = 1'b1;
               nxt_resp = '{code: MSG_SAVE_PROMPT, count: 16'(save_cnt_ff)};
               nxt_state = ST_SAVE_CONF;
            end else if (rx_valid) begin
               nxt_skip_err = MSG_E002;
               nxt_state = ST_SKIP;
            end
         end
         ST_SAVE_CONF: begin
            if (is_uy) begin
               nxt_nvm_write = 1'b1;
               nxt_state = ST_SAVE_WR;
            end else if (rx_valid) begin
               nxt_restore_tx = tx_dirty_ff;
               nxt_resp_valid = 1'b1;
               nxt_resp = '{code: MSG_SAVE_ABORT, count: 16'(save_cnt_ff)};
               // Any non-N answer is also flagged as an invalid value
               if (!is_un) begin
                  nxt_state = ST_SAVE_WARN;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end
         end
         ST_SAVE_WR: begin
            if (nvm_done) begin
               nxt_resp_valid = 1'b1;
               if (nvm_fail) begin
                  nxt_resp = '{code: MSG_E005, count: 16'(save_cnt_ff)};
                  nxt_state = ST_IDLE;
               end else begin
                  save_clr = 1'b1;
                  nxt_save_cnt = cnt_sat;
                  nxt_resp = '{code: MSG_SAVE_OK, count: 16'(cnt_sat)};
                  nxt_state = over_limit ? ST_SAVE_WARN : ST_IDLE;
               end
            end
         end
         ST_SAVE_WARN: begin
            // Second message of a pair; the code depends on the first
            nxt_resp_valid = 1'b1;
            nxt_resp.code = (resp_ff.code == MSG_SAVE_OK) ? MSG_E004 : MSG_E003;
            nxt_state = ST_IDLE;
         end
         ST_EXIT_SP: begin
            if (is_sp) begin
               nxt_state = ST_EXIT_ARG;
            end else if (rx_valid) begin
               nxt_skip_err = MSG_E002;
               nxt_state = is_cr ? ST_IDLE : ST_SKIP;
               nxt_resp_valid = is_cr;
               nxt_resp.code = MSG_E002;
            end
         end
         ST_EXIT_ARG: begin
            if (is_cr) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = MSG_E002;
               nxt_state = ST_IDLE;
            end else if (rx_valid) begin
               nxt_target_init = arg_i || arg_bi;
               nxt_fast = arg_bn || arg_bi;
               nxt_skip_err = arg_ok ? MSG_E002 : MSG_E003;
               nxt_state = ST_EXIT_END;
            end
         end
         ST_EXIT_END: begin
            if (is_cr && skip_err_ff == MSG_E003) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = MSG_E003;
               nxt_state = ST_IDLE;
            end else if (is_cr && fast_ff) begin
               // Immediate exit skips prompt and hold
               nxt_go_init = target_init_ff;
               nxt_go_normal = !target_init_ff;
               nxt_reload = target_init_ff;
               reload_clr = target_init_ff;
               nxt_resp_valid = 1'b1;
               nxt_resp.code = target_init_ff ? MSG_RET_INIT : MSG_RET_NORMAL;
               nxt_state = ST_IDLE;
            end else if (is_cr && unsaved_ff) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = MSG_EXIT_PROMPT;
               nxt_state = ST_EXIT_CONF;
            end else if (is_cr) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = target_init_ff ? MSG_RET_INIT : MSG_RET_NORMAL;
               nxt_hold = 32'h0;
               nxt_state = ST_HOLD;
            end else if (rx_valid) begin
               nxt_state = ST_SKIP;
            end
         end
         ST_EXIT_CONF: begin
            if (is_uy) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = target_init_ff ? MSG_RET_INIT : MSG_RET_NORMAL;
               nxt_hold = 32'h0;
               nxt_state = ST_HOLD;
            end else if (is_un) begin
               nxt_state = ST_IDLE;
            end else if (rx_valid) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = MSG_E003;
               nxt_state = ST_IDLE;
            end
         end
         ST_HOLD: begin
            // Gives the host time to read the response before the link changes
            nxt_hold = hold_ff + 32'h1;
            if (hold_done) begin
               nxt_go_init = target_init_ff;
               nxt_go_normal = !target_init_ff;
               nxt_reload = target_init_ff;
               reload_clr = target_init_ff;
               nxt_state = ST_IDLE;
            end
         end
         ST_SKIP: begin
            if (is_cr) begin
               nxt_resp_valid = 1'b1;
               nxt_resp.code = skip_err_ff;
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer and pulse registers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         save_cnt_ff <= CNT_W'(`SSEH_CNT_RST);
         hold_ff <= 32'h0;
         target_init_ff <= 1'b0;
         fast_ff <= 1'b0;
         skip_err_ff <= MSG_E001;
         resp_valid_ff <= 1'b0;
         resp_ff <= '{code: MSG_NONE, count: 16'h0000};
         nvm_write_ff <= 1'b0;
         restore_tx_ff <= 1'b0;
         reload_ff <= 1'b0;
         go_normal_ff <= 1'b0;
         go_init_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         save_cnt_ff <= nxt_save_cnt;
         hold_ff <= nxt_hold;
         target_init_ff <= nxt_target_init;
         fast_ff <= nxt_fast;
         skip_err_ff <= nxt_skip_err;
         resp_valid_ff <= nxt_resp_valid;
         resp_ff <= nxt_resp;
         nvm_write_ff <= nxt_nvm_write;
         restore_tx_ff <= nxt_restore_tx;
         reload_ff <= nxt_reload;
         go_normal_ff <= nxt_go_normal;
         go_init_ff <= nxt_go_init;
         busy_ff <= nxt_busy;
      end
   end

   // Unsaved and transmission-dirty flags; a change in the clearing cycle wins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         unsaved_ff <= 1'b0;
         tx_dirty_ff <= 1'b0;
      end else if (clk_en) begin
         unsaved_ff <= cfg_changed || tx_changed || (unsaved_ff && !save_clr && !reload_clr);
         tx_dirty_ff <= tx_changed || (tx_dirty_ff && !save_clr && !reload_clr && !nxt_restore_tx);
      end
   end

   assign resp_valid = resp_valid_ff;
   assign resp = resp_ff;
   assign nvm_write = nvm_write_ff;
   assign restore_tx = restore_tx_ff;
   assign reload_cfg = reload_ff;
   assign go_normal = go_normal_ff;
   assign go_init = go_init_ff;
   assign unsaved = unsaved_ff;
   assign busy = busy_ff;
endmodule : sseh_top

//--- tb/sseh_host.sv
`timescale 1ns/1ps
module sseh_host (
   input wire logic clock,
   input wire logic nvm_write,
   input wire logic fail_mode,
   input wire logic [2:0] nvm_lat,
   output logic rx_valid = 1'b0,
   output logic [7:0] rx_char = 8'hA5,
   output logic nvm_done = 1'b0,
   output logic nvm_fail = 1'b0
);
   logic [3:0] wait_ff = 4'h0;
   // Storage answers after a variable delay; the fail level wanders between answers
   always_ff @(posedge clock) begin
      wait_ff <= nvm_write ? {1'b0, nvm_lat} + 4'h1 : (wait_ff != 4'h0) ? wait_ff - 4'h1 : 4'h0;
      nvm_done <= wait_ff == 4'h1;
      nvm_fail <= (wait_ff == 4'h1) ? fail_mode : ~nvm_fail;
   end
   // Terminal types back to back; the idle line shows no stale character
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clock);
         rx_valid <= 1'b1;
         rx_char <= s[i];
      end
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_char <= ~rx_char;
   endtask : send
endmodule : sseh_host

//--- tb/sseh_props.sv
`timescale 1ns/1ps
module sseh_props import sseh_pkg::*; #(
   parameter int HOLD_CYCLES = 20,
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   input wire logic cfg_changed,
   input wire logic tx_changed,
   input wire logic nvm_done,
   input wire logic nvm_fail,
   input wire logic resp_valid,
   input wire sseh_resp_type resp,
   input wire logic nvm_write,
   input wire logic restore_tx,
   input wire logic reload_cfg,
   input wire logic go_normal,
   input wire logic go_init,
   input wire logic unsaved,
   input wire logic busy
);
   logic [31:0] hold_ff;
   logic [15:0] last_ff;
   // Decodes of the message stream; an answer only counts while a save prompt is the last word
   wire go_any = go_normal || go_init;
   wire ret_msg = resp_valid && (resp.code == MSG_RET_NORMAL || resp.code == MSG_RET_INIT);
   wire ok_msg = resp_valid && resp.code == MSG_SAVE_OK;
   wire answer = clk_en && rx_valid && !busy && resp.code == MSG_SAVE_PROMPT;
   // Cycles since a returning message; immediate exits never start the count, frozen cycles do not count
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         hold_ff <= 32'h0;
         last_ff <= 16'h0;
      end else if (clk_en) begin
         hold_ff <= (go_any || (hold_ff == 32'h0 && !ret_msg)) ? 32'h0 : hold_ff + 32'h1;
         last_ff <= ok_msg ? resp.count : last_ff;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   a_save_total: assert property (ok_msg |-> resp.count == last_ff + 16'h1)
      else $error("save total not one above the last");
   a_wear_warn: assert property (ok_msg && resp.count > 16'h03E8 |=> resp_valid && resp.code == MSG_E004)
      else $error("wear warning missing");
   a_early_warn: assert property (ok_msg && resp.count <= 16'h03E8 |=> !(resp_valid && resp.code == MSG_E004))
      else $error("wear warning too early");
   a_write_fail: assert property (nvm_done && nvm_fail |=> resp_valid && resp.code == MSG_E005)
      else $error("failed write not reported");
   a_confirm_write: assert property (answer && rx_char == 8'h59 |=> nvm_write)
      else $error("confirmed save did not write");
   a_lower_abort: assert property (answer && rx_char == 8'h79 |=> !nvm_write ##1 resp.code == MSG_E003)
      else $error("lower case answer not refused");
   a_restore_abort: assert property (restore_tx |-> resp_valid && resp.code == MSG_SAVE_ABORT)
      else $error("restore without aborted save");
   a_hold_time: assert property (go_any && hold_ff != 32'h0 |-> hold_ff == HOLD_CYCLES)
      else $error("mode change off the hold time");
   a_init_reload: assert property (go_init |-> reload_cfg)
      else $error("init entered without reload");
   cover property (nvm_done && nvm_fail);
   cover property (go_init && hold_ff != 32'h0);
   cover property (resp_valid && resp.code == MSG_E004);
endmodule : sseh_props
bind sseh_top sseh_props #(.HOLD_CYCLES(HOLD_CYCLES), .CNT_W(CNT_W)) u_sseh_props (.clock, .rstn, .clk_en,
   .rx_valid, .rx_char, .cfg_changed, .tx_changed, .nvm_done, .nvm_fail, .resp_valid, .resp, .nvm_write,
   .restore_tx, .reload_cfg, .go_normal, .go_init, .unsaved, .busy);

//--- tb/sseh_top_test.sv
`timescale 1ns/1ps
module sseh_top_test import sseh_pkg::*; ();
   localparam int HOLD = 20;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic cfg_changed = 1'b0;
   logic tx_changed = 1'b0;
   logic fail_mode = 1'b0;
   logic clk_en = 1'b1;
   logic [2:0] nvm_lat = 3'h1;
   logic rx_valid, nvm_done, nvm_fail, resp_valid, nvm_write, restore_tx, reload_cfg, go_normal, go_init, unsaved, busy;
   logic [7:0] rx_char;
   sseh_resp_type resp;
   sseh_resp_type msgs[$];
   int errors = 0;
   int checks_done = 0;
   int seed = 32'hAEC4;
   int cyc, ret_cyc, go_cyc, restores, reloads, saves;
   string bad[5] = '{"sa\015", "x\015", "xn\015", "x q\015", "x n1\015"};
   sseh_msg_type bad_code[5] = '{MSG_E002, MSG_E002, MSG_E002, MSG_E003, MSG_E002};
   sseh_top #(.HOLD_CYCLES(HOLD)) u_sseh_top (.clock, .rstn, .clk_en, .rx_valid, .rx_char, .cfg_changed,
      .tx_changed, .nvm_done, .nvm_fail, .resp_valid, .resp, .nvm_write, .restore_tx, .reload_cfg, .go_normal,
      .go_init, .unsaved, .busy);
   sseh_host u_sseh_host (.clock, .nvm_write, .fail_mode, .nvm_lat, .rx_valid, .rx_char, .nvm_done, .nvm_fail);
   initial begin
      forever #20 clock = ~clock;
   end
   // Log messages and mode pulses by cycle; the ceiling cuts a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (resp_valid) msgs.push_back(resp);
      if (ret_msg_seen()) ret_cyc <= cyc;
      if (go_normal || go_init) go_cyc <= cyc;
      restores <= restores + int'(restore_tx);
      reloads <= reloads + int'(reload_cfg);
      if (cyc == 60000) begin
         errors++;
         stop_test();
      end
   end
   function automatic logic ret_msg_seen();
      return resp_valid && resp.code inside {MSG_RET_NORMAL, MSG_RET_INIT};
   endfunction : ret_msg_seen
   function automatic sseh_resp_type exp_ok(input int n);
      return '{code: MSG_SAVE_OK, count: 16'(n)};
   endfunction : exp_ok
   // Random command letter, steered away from the two this block serves
   function automatic string bad_letter();
      byte c = 8'h61 + 8'($unsigned($random(seed)) % 26);
      return $sformatf("%c\015", (c == "s" || c == "x") ? "q" : c);
   endfunction : bad_letter
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic next_msg(output sseh_resp_type r);
      r = '0;
      for (int i = 0; i < 40 && msgs.size() == 0; i++) begin
         @(posedge clock);
         #1;
      end
      if (msgs.size() != 0) r = msgs.pop_front();
   endtask : next_msg
   task automatic expect_code(input sseh_msg_type c);
      sseh_resp_type r;
      next_msg(r);
      check(20'(r.code), 20'(c));
   endtask : expect_code
   task automatic wait_idle();
      for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clock);
      repeat (2) @(posedge clock);
      #1;
   endtask : wait_idle
   task automatic pulse(input logic tx);
      @(posedge clock);
      tx_changed <= tx;
      cfg_changed <= !tx;
      @(posedge clock);
      tx_changed <= 1'b0;
      cfg_changed <= 1'b0;
   endtask : pulse
   task automatic do_save(input byte a);
      sseh_resp_type r;
      u_sseh_host.send("s\015");
      expect_code(MSG_SAVE_PROMPT);
      u_sseh_host.send($sformatf("%c", a));
      if (a != "Y") begin
         expect_code(MSG_SAVE_ABORT);
         if (a != "N") expect_code(MSG_E003);
      end else if (fail_mode) begin
         expect_code(MSG_E005);
      end else begin
         saves++;
         next_msg(r);
         check(r, exp_ok(saves));
         if (saves > 1000) expect_code(MSG_E004);
      end
      wait_idle();
   endtask : do_save
   task automatic done_test(input string n);
      $display("test %s ended: %0d checks, %0d wrong", n, checks_done, errors);
   endtask : done_test
   task automatic stop_test();
      $display("checks %0d, wrong %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // Main sequence: saves, malformed commands, exits, then the wear threshold
   initial begin
      string ans;
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      do_save("Y");
      fail_mode = 1'b1;
      do_save("Y");
      fail_mode = 1'b0;
      ans = "NyQ";
      for (int i = 0; i < 3; i++) begin
         pulse(1'b1);
         do_save(ans[i]);
         check(20'(restores), 20'(i + 1));
      end
      for (int i = 0; i < 10; i++) begin
         u_sseh_host.send(i < 5 ? bad[i] : bad_letter());
         expect_code(i < 5 ? bad_code[i] : MSG_E001);
      end
      done_test("save");
      do_save("Y");
      u_sseh_host.send("x n\015");
      expect_code(MSG_RET_NORMAL);
      // Clock enable low for five edges stretches the hold by exactly five
      @(posedge clock);
      clk_en <= 1'b0;
      repeat (5) @(posedge clock);
      clk_en <= 1'b1;
      wait_idle();
      check(20'(go_cyc - ret_cyc), 20'(HOLD + 5));
      pulse(1'b0);
      ans = "nNY";
      for (int i = 0; i < 3; i++) begin
         u_sseh_host.send("x i\015");
         expect_code(MSG_EXIT_PROMPT);
         u_sseh_host.send(ans.substr(i, i));
         if (i == 0) expect_code(MSG_E003);
      end
      expect_code(MSG_RET_INIT);
      wait_idle();
      check(20'(go_cyc - ret_cyc), 20'(HOLD));
      check(20'(unsaved), 20'h0);
      ans = "NI";
      for (int i = 0; i < 2; i++) begin
         pulse(1'b0);
         u_sseh_host.send({"x ", ans.substr(i, i), "\015"});
         expect_code(i == 0 ? MSG_RET_NORMAL : MSG_RET_INIT);
         wait_idle();
         check(20'(go_cyc - ret_cyc), 20'h0);
      end
      check(20'(reloads), 20'h2);
      done_test("exit");
      while (saves < 1002) begin
         nvm_lat = 3'($random(seed));
         do_save("Y");
      end
      done_test("wear");
      stop_test();
   end
endmodule : sseh_top_test
